// file: verilog/wiper_serial_ctrl.sv
// Overview of operation
// - Each rising serial clock edge with select low shifts exactly one input bit in, except while a busy command locks the register.
// - Select is active low and the captured word is executed only after select rises.
// - A word is 24 bits: command nibble, address nibble, six spare bits, 10-bit data.
// - Address zero picks channel one and its store, address one picks channel two.
// - The open-drain serial output is actively driven only for read commands 9 and 10.
// - With write protect low, save and write store are not started; one already busy still writes its store.
// - The hardware preset reloads both wipers from their stored values at any time.
// - Unprogrammed stored values hold midscale 512, so a reload gives midscale.
// - Ready is pulled low while commands 2, 3, 8, 9 or 10 run and released when done.
// - A save lasts 20.2 ms with the input register locked, and ready rises at the end.
// - A select strobe with no new bits repeats the previous frame's command when that was a step, shift or halving command.
// - After power-on each wiper is loaded from its stored value.
// - Words arrive most significant bit first, the first bit being the top command bit.
// - Commands: 0 idle, 1 reload, 2 save, 3 write store, 8 reload all, 9/10 read, 11 write.
// - After a read the output repeats the command byte, then the low 16 carry the chosen register.
// - Decrement stops at zero, increment at all ones, halving rotates, doubling saturates.
module wiper_serial_ctrl #(
  parameter int SAVE_CYCLES_P = wiper_pkg::SAVE_CYCLES,
  parameter int RELOAD_ALL_CYCLES_P = wiper_pkg::RELOAD_ALL_CYCLES,
  parameter int READ_CYCLES_P = wiper_pkg::READ_CYCLES
) (
  // System clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // Serial link
  input wire logic i_serial_clock,
  input wire logic i_select_n,
  input wire logic i_serial_in,
  output logic o_serial_out,
  output logic o_serial_out_oe,
  // Control pins
  input wire logic i_write_protect_n,
  input wire logic i_hardware_preset_n,
  output logic o_ready,
  output logic o_ready_oe,
  // Wiper and store contents
  output logic [wiper_pkg::WIPER_BITS-1:0] o_wiper_setting_channel_one,
  output logic [wiper_pkg::WIPER_BITS-1:0] o_wiper_setting_channel_two,
  output logic [wiper_pkg::WIPER_BITS-1:0] o_store_channel_one,
  output logic [wiper_pkg::WIPER_BITS-1:0] o_store_channel_two
);
  import wiper_pkg::*;

  // ****************************************
  // Link domain
  // ****************************************
  logic [WORD_BITS-1:0] shift_word;
  logic [WORD_BITS-1:0] next_shift_word;
  logic [COUNT_BITS-1:0] bit_count;
  logic frame_mark;
  logic next_frame_mark;
  logic link_rst;
  logic link_lock;
  logic link_read_mode;
  logic read_mode;
  logic [READ_BITS-1:0] read_word;
  logic busy;
  logic out_bit;

  level_sync u_rst_sync (
    .i_clock(i_serial_clock),
    .i_level(i_sys_rst),
    .o_level(link_rst)
  );

  // Lock level from the busy state (save, write store, reload all or read)
  level_sync u_lock_sync (
    .i_clock(i_serial_clock),
    .i_level(busy),
    .o_level(link_lock)
  );

  // Read mode only moves while select is high and the link clock is parked, so it is
  // a steady level here; a sync stage on the parked clock would lag a whole frame
  assign link_read_mode = read_mode;

  // Shift next value, MSB first, newest 24 bits kept
  always_comb begin
    next_shift_word = shift_word;
    next_frame_mark = frame_mark;
    if (!link_lock) begin
      next_shift_word = {shift_word[WORD_BITS-2:0], i_serial_in};
      if (bit_count == '0) begin
        next_frame_mark = ~frame_mark;
      end
    end
  end

  // Shift while select is low; marker clears only outside a frame as link reset lags
  always_ff @(posedge i_serial_clock) begin
    if (!i_select_n) begin
      shift_word <= next_shift_word;
      frame_mark <= next_frame_mark;
    end else if (link_rst) begin
      frame_mark <= 1'b0;
    end
  end

  // Bit counter cleared while select is high; the clock may stop outside a frame
  always_ff @(posedge i_serial_clock or posedge i_select_n) begin
    if (i_select_n) begin
      bit_count <= '0;
    end else if (bit_count != WORD_BITS_CNT) begin
      bit_count <= bit_count + 5'h01;
    end
  end

  // Readback bits replace the low 16 once the command byte has gone out
  always_comb begin
    out_bit = shift_word[WORD_BITS-1];
    if (link_read_mode && bit_count >= READ_START_BIT && bit_count < WORD_BITS_CNT) begin
      out_bit = read_word[READ_BITS - 1 - 32'(bit_count - READ_START_BIT)];
    end
  end

  // Open drain: pull low only for a zero while a read is pending
  assign o_serial_out = 1'b0;
  assign o_serial_out_oe = !i_select_n && link_read_mode && !out_bit;

  // ****************************************
  // System domain inputs
  // ****************************************
  logic select_sync;
  logic mark_sync;
  logic protect_n_sync;
  logic preset_n_sync;
  logic select_prev;
  logic capture_due;
  logic mark_seen;

  level_sync u_sel_sync (
    .i_clock(i_clock),
    .i_level(i_select_n),
    .o_level(select_sync)
  );
  level_sync u_mark_sync (
    .i_clock(i_clock),
    .i_level(frame_mark),
    .o_level(mark_sync)
  );
  level_sync u_wp_sync (
    .i_clock(i_clock),
    .i_level(i_write_protect_n),
    .o_level(protect_n_sync)
  );
  level_sync u_pr_sync (
    .i_clock(i_clock),
    .i_level(i_hardware_preset_n),
    .o_level(preset_n_sync)
  );

  // ****************************************
  // Command execution
  // ****************************************
  typedef enum logic [1:0] {
    ST_INIT = 2'b00,
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } state_e;

  state_e state;
  state_e next_state;
  logic [WIPER_BITS-1:0] wiper [CHANNELS];
  logic [WIPER_BITS-1:0] next_wiper [CHANNELS];
  logic [WIPER_BITS-1:0] store [CHANNELS];
  logic [WIPER_BITS-1:0] next_store [CHANNELS];
  logic [BUSY_BITS-1:0] busy_count;
  logic [BUSY_BITS-1:0] next_busy_count;
  command_e pend_cmd;
  command_e next_pend_cmd;
  logic pend_chan;
  logic next_pend_chan;
  logic [WIPER_BITS-1:0] pend_data;
  logic [WIPER_BITS-1:0] next_pend_data;
  command_e step_cmd;
  command_e next_step_cmd;
  logic step_chan;
  logic next_step_chan;
  logic step_valid;
  logic next_step_valid;
  logic next_read_mode;
  logic [READ_BITS-1:0] next_read_word;
  logic next_mark_seen;

  // Step commands that repeat on a bare select strobe
  function automatic logic is_step(input command_e c);
    is_step = (c[3:2] == 2'b01) || (c[3:2] == 2'b11);
  endfunction

  // New value of one wiper under a step command
  function automatic logic [WIPER_BITS-1:0] step_value(input command_e c,
                                                       input logic [WIPER_BITS-1:0] v);
    case (c)
      CMD_HALVE_ONE, CMD_HALVE_ALL: step_value = {v[0], v[WIPER_BITS-1:1]};
      CMD_DEC_ONE, CMD_DEC_ALL: step_value = (v == WIPER_ZERO) ? v : v - 10'h001;
      CMD_DOUBLE_ONE, CMD_DOUBLE_ALL: step_value = v[WIPER_BITS-1] ? WIPER_FULL :
                                                   {v[WIPER_BITS-2:0], 1'b0};
      CMD_INC_ONE, CMD_INC_ALL: step_value = (v == WIPER_FULL) ? v : v + 10'h001;
      default: step_value = v;
    endcase
  endfunction

  // Address decode: only channel indices zero and one exist
  function automatic logic addr_ok(input logic [3:0] a);
    addr_ok = (a == ADDR_WIPER_SETTING_CHANNEL_ONE) || (a == ADDR_WIPER_SETTING_CHANNEL_TWO);
  endfunction

  // Capture one cycle after the synchronised select rise, word is stable by then
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      select_prev <= 1'b1;
      capture_due <= 1'b0;
    end else begin
      select_prev <= select_sync;
      capture_due <= select_sync && !select_prev;
    end
  end

  // Next state of the executor
  always_comb begin
    command_e cmd;
    logic chan;
    logic fresh;
    logic run;
    cmd = command_e'(shift_word[CMD_MSB:CMD_LSB]);
    chan = shift_word[ADDR_LSB];
    fresh = (mark_sync != mark_seen);
    run = 1'b0;
    next_state = state;
    next_wiper = wiper;
    next_store = store;
    next_busy_count = busy_count;
    next_pend_cmd = pend_cmd;
    next_pend_chan = pend_chan;
    next_pend_data = pend_data;
    next_step_cmd = step_cmd;
    next_step_chan = step_chan;
    next_step_valid = step_valid;
    next_read_mode = read_mode;
    next_read_word = read_word;
    next_mark_seen = mark_seen;
    case (state)
      ST_INIT: begin
        next_wiper = store;
        next_mark_seen = mark_sync; // Align to the link marker, whatever it holds
        next_state = ST_IDLE;
      end
      ST_IDLE: begin
        if (capture_due) begin
          next_mark_seen = mark_sync;
          next_read_mode = 1'b0;
          if (!fresh) begin
            run = step_valid;
            cmd = step_cmd;
            chan = step_chan;
          end else begin
            run = addr_ok(shift_word[ADDR_MSB:ADDR_LSB]) || cmd[0] && is_step(cmd) ||
                  cmd == CMD_NO_OPERATION || cmd == CMD_RELOAD_ALL;
            next_step_valid = 1'b0;
          end
        end
        if (run) begin
          next_pend_cmd = cmd;
          next_pend_chan = chan;
          next_pend_data = shift_word[DATA_MSB:DATA_LSB];
          case (cmd)
            CMD_RELOAD_ONE: next_wiper[chan] = store[chan];
            CMD_WRITE_WIPER: next_wiper[chan] = shift_word[DATA_MSB:DATA_LSB];
            CMD_SAVE_WIPER, CMD_WRITE_STORE: begin
              if (protect_n_sync) begin
                next_busy_count = BUSY_BITS'(SAVE_CYCLES_P - 1);
                next_state = ST_BUSY;
              end
            end
            CMD_RELOAD_ALL: begin
              next_busy_count = BUSY_BITS'(RELOAD_ALL_CYCLES_P - 1);
              next_state = ST_BUSY;
            end
            CMD_READ_STORE, CMD_READ_WIPER: begin
              next_read_word = {6'h00, (cmd == CMD_READ_STORE) ? store[chan] : wiper[chan]};
              next_read_mode = 1'b1;
              next_busy_count = BUSY_BITS'(READ_CYCLES_P - 1);
              next_state = ST_BUSY;
            end
            default: begin
              if (is_step(cmd)) begin
                next_step_cmd = cmd;
                next_step_chan = chan;
                next_step_valid = 1'b1;
                if (cmd[0]) begin
                  for (int i = 0; i < CHANNELS; i++) begin
                    next_wiper[i] = step_value(cmd, wiper[i]);
                  end
                end else begin
                  next_wiper[chan] = step_value(cmd, wiper[chan]);
                end
              end
            end
          endcase
        end
      end
      ST_BUSY: begin
        // Frames arriving now are dropped; shifting is locked meanwhile
        next_mark_seen = mark_sync;
        if (busy_count != '0) begin
          next_busy_count = busy_count - 22'h000001;
        end else begin
          next_state = ST_IDLE;
          case (pend_cmd)
            CMD_SAVE_WIPER: next_store[pend_chan] = wiper[pend_chan];
            CMD_WRITE_STORE: next_store[pend_chan] = pend_data;
            CMD_RELOAD_ALL: next_wiper = store;
            default: next_read_word = read_word;
          endcase
        end
      end
      default: next_state = ST_INIT;
    endcase
    if (!preset_n_sync) begin
      next_wiper = store;
    end
  end

  // Register the executor state
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      state <= ST_INIT;
      store <= '{default: STORE_MIDSCALE};
      wiper <= '{default: STORE_MIDSCALE};
      busy_count <= '0;
      pend_cmd <= CMD_NO_OPERATION;
      pend_chan <= 1'b0;
      pend_data <= '0;
      step_cmd <= CMD_NO_OPERATION;
      step_chan <= 1'b0;
      step_valid <= 1'b0;
      read_mode <= 1'b0;
      read_word <= '0;
      mark_seen <= 1'b0;
    end else begin
      state <= next_state;
      store <= next_store;
      wiper <= next_wiper;
      busy_count <= next_busy_count;
      pend_cmd <= next_pend_cmd;
      pend_chan <= next_pend_chan;
      pend_data <= next_pend_data;
      step_cmd <= next_step_cmd;
      step_chan <= next_step_chan;
      step_valid <= next_step_valid;
      read_mode <= next_read_mode;
      read_word <= next_read_word;
      mark_seen <= next_mark_seen;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign busy = (state == ST_BUSY);
  assign o_ready = 1'b0;
  assign o_ready_oe = busy;
  assign o_wiper_setting_channel_one = wiper[0];
  assign o_wiper_setting_channel_two = wiper[1];
  assign o_store_channel_one = store[0];
  assign o_store_channel_two = store[1];
endmodule

// file: verilog/wiper_pkg.sv
package wiper_pkg;
  // ****************************************
  // Word layout
  // ****************************************
  localparam int WORD_BITS = 24;
  localparam int CMD_MSB = 23;
  localparam int CMD_LSB = 20;
  localparam int ADDR_MSB = 19;
  localparam int ADDR_LSB = 16;
  localparam int DATA_MSB = 9;
  localparam int DATA_LSB = 0;
  localparam int WIPER_BITS = 10;
  localparam int READ_BITS = 16;
  localparam int CHANNELS = 2;
  localparam int COUNT_BITS = 5;
  localparam logic [COUNT_BITS-1:0] READ_START_BIT = 5'h08;
  localparam logic [COUNT_BITS-1:0] WORD_BITS_CNT = 5'h18;

  // ****************************************
  // Register indices and reset values
  // ****************************************
  localparam logic [3:0] ADDR_WIPER_SETTING_CHANNEL_ONE = 4'h0;
  localparam logic [3:0] ADDR_WIPER_SETTING_CHANNEL_TWO = 4'h1;
  localparam logic [WIPER_BITS-1:0] STORE_MIDSCALE = 10'h200;
  localparam logic [WIPER_BITS-1:0] WIPER_FULL = 10'h3FF;
  localparam logic [WIPER_BITS-1:0] WIPER_ZERO = 10'h000;

  // ****************************************
  // Commands
  // ****************************************
  typedef enum logic [3:0] {
    CMD_NO_OPERATION = 4'b0000,
    CMD_RELOAD_ONE = 4'b0001,
    CMD_SAVE_WIPER = 4'b0010,
    CMD_WRITE_STORE = 4'b0011,
    CMD_HALVE_ONE = 4'b0100,
    CMD_HALVE_ALL = 4'b0101,
    CMD_DEC_ONE = 4'b0110,
    CMD_DEC_ALL = 4'b0111,
    CMD_RELOAD_ALL = 4'b1000,
    CMD_READ_STORE = 4'b1001,
    CMD_READ_WIPER = 4'b1010,
    CMD_WRITE_WIPER = 4'b1011,
    CMD_DOUBLE_ONE = 4'b1100,
    CMD_DOUBLE_ALL = 4'b1101,
    CMD_INC_ONE = 4'b1110,
    CMD_INC_ALL = 4'b1111
  } command_e;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLOCK_MHZ = 125;
  localparam int SAVE_TIME_US = 20200;
  localparam int RELOAD_ALL_TIME_US = 1000;
  localparam int READ_TIME_US = 100;
  localparam int SAVE_CYCLES = SAVE_TIME_US * CLOCK_MHZ;
  localparam int RELOAD_ALL_CYCLES = RELOAD_ALL_TIME_US * CLOCK_MHZ;
  localparam int READ_CYCLES = READ_TIME_US * CLOCK_MHZ;
  localparam int BUSY_BITS = 22;
endpackage

// file: verilog/level_sync.sv
// Two-stage synchroniser for a level entering a clock domain
module level_sync (
  // Clock
  input wire logic i_clock,
  // Level in and out
  input wire logic i_level,
  output logic o_level
);
  logic stage_one;
  logic stage_two;

  // First stage feeds only the second
  always_ff @(posedge i_clock) begin
    stage_one <= i_level;
    stage_two <= stage_one;
  end

  assign o_level = stage_two;
endmodule

// file: sim/wiper_monitor.sv
module wiper_monitor #(
  parameter int SAVE_CYCLES_P = wiper_pkg::SAVE_CYCLES,
  parameter int RELOAD_ALL_CYCLES_P = wiper_pkg::RELOAD_ALL_CYCLES,
  parameter int READ_CYCLES_P = wiper_pkg::READ_CYCLES
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // Link and control pins
  input wire logic i_serial_clock,
  input wire logic i_select_n,
  input wire logic i_serial_in,
  input wire logic o_serial_out,
  input wire logic o_serial_out_oe,
  input wire logic i_write_protect_n,
  input wire logic i_hardware_preset_n,
  input wire logic o_ready,
  input wire logic o_ready_oe,
  // Wipers and stores
  input wire logic [wiper_pkg::WIPER_BITS-1:0] o_wiper_setting_channel_one,
  input wire logic [wiper_pkg::WIPER_BITS-1:0] o_wiper_setting_channel_two,
  input wire logic [wiper_pkg::WIPER_BITS-1:0] o_store_channel_one,
  input wire logic [wiper_pkg::WIPER_BITS-1:0] o_store_channel_two
);
  timeunit 1ns;
  timeprecision 100ps;
  import wiper_pkg::*;
  // *****
  // Helper counters
  // *****
  logic [BUSY_BITS-1:0] busy_cnt, next_busy_cnt;
  logic [2:0] wp_cnt, next_wp_cnt, pr_cnt, next_pr_cnt;
  // Pins pass two sync flops, so counts saturate well past that depth
  always_comb begin
    next_busy_cnt = o_ready_oe ? busy_cnt + 1'b1 : '0;
    next_wp_cnt = i_write_protect_n ? 3'h0 : wp_cnt + {2'h0, wp_cnt != 3'h7};
    next_pr_cnt = i_hardware_preset_n ? 3'h0 : pr_cnt + {2'h0, pr_cnt != 3'h7};
    if (i_sys_rst) begin
      next_busy_cnt = '0;
      next_wp_cnt = 3'h0;
      next_pr_cnt = 3'h0;
    end
  end
  // Register the counters
  always_ff @(posedge i_clock) begin
    busy_cnt <= next_busy_cnt;
    wp_cnt <= next_wp_cnt;
    pr_cnt <= next_pr_cnt;
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  a_ready_pin_low: assert property (o_ready == 1'b0)
    else $error("ready pin value not low");
  a_sdo_pin_low: assert property (o_serial_out == 1'b0)
    else $error("serial out value not low");
  a_sdo_idle_off: assert property (i_select_n |-> !o_serial_out_oe)
    else $error("serial out driven while deselected");
  a_busy_exact_len: assert property ($fell(o_ready_oe) |->
    (int'(busy_cnt) == SAVE_CYCLES_P || int'(busy_cnt) == RELOAD_ALL_CYCLES_P
    || int'(busy_cnt) == READ_CYCLES_P)) else $error("busy length wrong");
  a_busy_min_len: assert property ($rose(o_ready_oe) |-> o_ready_oe[*5])
    else $error("busy too short");
  a_exec_after_select: assert property ($rose(o_ready_oe) |->
    i_select_n && $past(i_select_n, 2)) else $error("busy began inside a frame");
  a_wiper_when_idle: assert property (($changed(o_wiper_setting_channel_one) ||
    $changed(o_wiper_setting_channel_two)) |-> i_select_n) else $error("wiper moved in frame");
  a_protect_blocks: assert property (wp_cnt >= 3'h4 |->
    $stable(o_store_channel_one) && $stable(o_store_channel_two)) else $error("store changed");
  a_preset_tracks: assert property (pr_cnt >= 3'h5 |->
    o_wiper_setting_channel_one == o_store_channel_one &&
    o_wiper_setting_channel_two == o_store_channel_two) else $error("preset not applied");
  a_store_after_busy: assert property (($changed(o_store_channel_one) ||
    $changed(o_store_channel_two)) |-> $past(o_ready_oe)) else $error("store write not busy");
endmodule

bind wiper_serial_ctrl wiper_monitor #(
  .SAVE_CYCLES_P(SAVE_CYCLES_P),
  .RELOAD_ALL_CYCLES_P(RELOAD_ALL_CYCLES_P),
  .READ_CYCLES_P(READ_CYCLES_P)
) mon_u (
  .i_clock, .i_sys_rst, .i_serial_clock, .i_select_n, .i_serial_in, .o_serial_out,
  .o_serial_out_oe, .i_write_protect_n, .i_hardware_preset_n, .o_ready, .o_ready_oe,
  .o_wiper_setting_channel_one, .o_wiper_setting_channel_two,
  .o_store_channel_one, .o_store_channel_two
);

// file: sim/spi_host_model.sv
module spi_host_model (
  // Link pins
  output logic o_serial_clock,
  output logic o_select_n,
  output logic o_serial_in,
  input wire logic i_serial_out_level
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle link: deselected, clock parked low
  initial begin
    o_serial_clock = 1'b0;
    o_select_n = 1'b1;
    o_serial_in = 1'b0;
  end
  // A few clocks under reset so the link side leaves it cleanly
  task idle_clocks();
    repeat (3) begin
      #16 o_serial_clock = 1'b1;
      #16 o_serial_clock = 1'b0;
    end
  endtask
  // One frame, 32 ns clock, wire sampled just before each rise
  task xfer(input logic [27:0] w, input int n, output logic [23:0] r);
    r = 24'h000000;
    o_select_n = 1'b0;
    #16;
    for (int i = n - 1; i >= 0; i--) begin
      o_serial_in = w[i];
      #16;
      r = {r[22:0], i_serial_out_level};
      o_serial_clock = 1'b1;
      #16 o_serial_clock = 1'b0;
    end
    #16 o_select_n = 1'b1;
    o_serial_in = ~o_serial_in; // released line must not keep its value
  endtask
endmodule

// file: sim/dual_wiper_serial_command_control_tb.sv
module dual_wiper_serial_command_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import wiper_pkg::*;
  // *****
  // Bench
  // *****
  logic i_clock = 1'b0;
  logic i_sys_rst = 1'b1;
  logic wp_n = 1'b1;
  logic preset_n = 1'b1;
  logic sclk, sel_n, sdi, sdo, sdo_oe, rdy, rdy_oe;
  logic [WIPER_BITS-1:0] w1, w2, s1, s2;
  logic [23:0] rx;
  int busy;
  int failures = 0;
  int n_checks = 0;
  logic [23:0] step_tab [8] = '{{4'h4, 10'h005, 10'h202}, {4'h5, 10'h202, 10'h101},
    {4'h6, 10'h000, 10'h000}, {4'h7, 10'h001, 10'h000}, {4'hC, 10'h201, 10'h3FF},
    {4'hD, 10'h0FF, 10'h1FE}, {4'hE, 10'h3FF, 10'h3FF}, {4'hF, 10'h1FF, 10'h200}};
  wire sdo_level = sdo_oe ? sdo : 1'b1; // pull-up on the open drain
  // 125 MHz system clock
  always #4 i_clock = ~i_clock;
  wiper_serial_ctrl #(.SAVE_CYCLES_P(20), .RELOAD_ALL_CYCLES_P(10), .READ_CYCLES_P(5)) dut_u (
    .i_clock, .i_sys_rst, .i_serial_clock(sclk), .i_select_n(sel_n), .i_serial_in(sdi),
    .o_serial_out(sdo), .o_serial_out_oe(sdo_oe), .i_write_protect_n(wp_n),
    .i_hardware_preset_n(preset_n), .o_ready(rdy), .o_ready_oe(rdy_oe),
    .o_wiper_setting_channel_one(w1), .o_wiper_setting_channel_two(w2),
    .o_store_channel_one(s1), .o_store_channel_two(s2));
  spi_host_model host_u (.o_serial_clock(sclk), .o_select_n(sel_n), .o_serial_in(sdi),
    .i_serial_out_level(sdo_level));
  function automatic logic [27:0] wd(input logic [3:0] c, a, input logic [9:0] d);
    return {4'h0, c, a, 6'h00, d};
  endfunction
  task chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Frame, then a window longer than a save, counting busy cycles
  task run(input logic [27:0] w, input int n);
    host_u.xfer(w, n, rx);
    busy = 0;
    repeat (40) begin
      @(negedge i_clock);
      if (rdy_oe === 1'b1) busy++;
    end
  endtask
  task t_init();
    chk({4'h0, w1, w2}, {4'h0, STORE_MIDSCALE, STORE_MIDSCALE});
    chk({4'h0, s1, s2}, {4'h0, STORE_MIDSCALE, STORE_MIDSCALE});
  endtask
  task t_write();
    run(wd(4'hB, 4'h0, 10'h3A5), 24);
    chk(24'(busy), 24'h000000);
    run(wd(4'hB, 4'h1, 10'h05A), 24);
    run(wd(4'hB, 4'h2, 10'h111), 24);
    chk({4'h0, w1, w2}, {4'h0, 10'h3A5, 10'h05A});
    run(wd(4'hB, 4'h0, 10'h123) | 28'hF000000, 28);
    chk({4'h0, w1, w2}, {4'h0, 10'h123, 10'h05A});
  endtask
  task t_steps();
    for (int i = 0; i < 8; i++) begin
      run(wd(4'hB, 4'h1, step_tab[i][19:10]), 24);
      run(wd(step_tab[i][23:20], 4'h1, 10'h000), 24);
      chk({14'h0000, w2}, {14'h0000, step_tab[i][9:0]});
    end
    run(wd(4'hB, 4'h1, 10'h005), 24);
    run(wd(4'h6, 4'h1, 10'h000), 24);
    run(28'h0000000, 0);
    run(28'h0000000, 0);
    chk({14'h0000, w2}, {14'h0000, 10'h002});
    run(wd(4'hB, 4'h1, 10'h009), 24);
    run(28'h0000000, 0);
    chk({14'h0000, w2}, {14'h0000, 10'h009});
  endtask
  task t_save();
    @(negedge i_clock) wp_n = 1'b0;
    run(wd(4'h3, 4'h0, 10'h155), 24);
    chk(24'(busy), 24'h000000);
    run(wd(4'hB, 4'h0, 10'h2AA), 24);
    run(wd(4'h2, 4'h0, 10'h000), 24);
    chk({4'h0, s1, w1}, {4'h0, STORE_MIDSCALE, 10'h2AA});
    @(negedge i_clock) wp_n = 1'b1;
    run(wd(4'h3, 4'h1, 10'h155), 24);
    chk(24'(busy), 24'h000014);
    run(wd(4'h2, 4'h0, 10'h000), 24);
    chk(24'(busy), 24'h000014);
    chk({4'h0, s1, s2}, {4'h0, 10'h2AA, 10'h155});
  endtask
  task t_read();
    run(wd(4'hA, 4'h0, 10'h000), 24);
    chk(24'(busy), 24'h000005);
    run(wd(4'h9, 4'h1, 10'h000), 24);
    chk(rx, {8'hA0, 6'h00, 10'h2AA});
    run(wd(4'h0, 4'h0, 10'h000), 24);
    chk(rx, {8'h91, 6'h00, 10'h155});
    run(wd(4'h0, 4'h0, 10'h000), 24);
    chk(rx, 24'hFFFFFF);
  endtask
  task t_reload();
    run(wd(4'hB, 4'h0, 10'h001), 24);
    run(wd(4'hB, 4'h1, 10'h002), 24);
    run(wd(4'h1, 4'h1, 10'h000), 24);
    chk({4'h0, w1, w2}, {4'h0, 10'h001, 10'h155});
    run(wd(4'h8, 4'h0, 10'h000), 24);
    chk(24'(busy), 24'h00000A);
    chk({4'h0, w1, w2}, {4'h0, 10'h2AA, 10'h155});
    run(wd(4'hB, 4'h0, 10'h3F0), 24);
    run(wd(4'hB, 4'h1, 10'h00F), 24);
    @(negedge i_clock) preset_n = 1'b0;
    repeat (8) @(negedge i_clock);
    chk({4'h0, w1, w2}, {4'h0, 10'h2AA, 10'h155});
    preset_n = 1'b1;
  endtask
  task complete_run();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Reset spans the link clocks the link side needs to clear
  initial begin
    fork
      host_u.idle_clocks();
      repeat (5) @(negedge i_clock);
    join
    @(negedge i_clock) i_sys_rst = 1'b0;
    repeat (4) @(negedge i_clock);
    t_init();
    t_write();
    t_steps();
    t_save();
    t_read();
    t_reload();
    complete_run();
  end
  // Watchdog, about four and a half times the expected run
  initial begin
    #200000;
    failures++;
    complete_run();
  end
endmodule
